// ==== dsh_regs.sv ====
// dsh_regs: received-header config register bank with axi4-lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module dsh_regs
  import dsh_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // axi4-lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read address
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // received header from the demodulator
  input  wire logic        HDR_VALID,
  input  wire dsh_hdr_type HDR,
  input  wire logic        HDR_CRC_OK,
  // dwell, sfd and timing strobes
  input  wire logic        DWELL_DONE,
  input  wire logic        SFD_SEARCH_START,
  input  wire logic        SFD_MATCH,
  input  wire logic        FRAME_END,
  input  wire logic        SYMBOL_TICK,
  input  wire logic        BIT_TICK,
  input  wire logic        BPSK_TICK,
  // pin inputs
  input  wire logic        RECEIVE_POWER_ENABLE,
  // transmit modulation select
  input  wire logic        TX_QPSK_SEL,
  // status and control outputs
  output logic             CCA_BUSY,
  output logic             MODEM_READY_OUT,
  output logic             SFD_TIMEOUT,
  output logic [7:0]       TX_SIGNAL_CODE,
  output logic             RX_IS_DBPSK,
  output logic             RX_IS_DQPSK,
  output logic [3:0]       CRC_COVER
);

  // ==========================================================
  // register storage
  logic [7:0]  modem_config_e_q;
  logic [7:0]  header_control_reg_q;
  logic [7:0]  sfd_search_time_q;
  logic [7:0]  dbpsk_signal_code_q;
  logic [7:0]  dqpsk_signal_code_q;
  logic [7:0]  rx_service_field_q;
  logic [7:0]  rx_length_high_q;
  logic [7:0]  rx_length_low_q;
  logic [7:0]  rx_header_crc_high_q;
  logic [7:0]  rx_header_crc_low_q;

  // ==========================================================
  // axi write channel state
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_addr_q;
  logic [7:0]  w_data_q;
  logic        w_lane0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  wire         aw_take   = S_AXI_AWVALID & S_AXI_AWREADY;
  wire         w_take    = S_AXI_WVALID & S_AXI_WREADY;
  wire         aw_have   = aw_held_q | aw_take;
  wire         w_have    = w_held_q | w_take;
  wire         wr_fire   = aw_have & w_have & ~bvalid_q;
  wire [7:0]   wr_addr   = aw_held_q ? aw_addr_q : S_AXI_AWADDR;
  wire [7:0]   wr_byte   = w_held_q ? w_data_q : S_AXI_WDATA[7:0];
  wire         wr_lane0  = w_held_q ? w_lane0_q : S_AXI_WSTRB[0];

  assign S_AXI_AWREADY = ~aw_held_q & ~bvalid_q;
  assign S_AXI_WREADY  = ~w_held_q & ~bvalid_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;

  // ==========================================================
  // write decode
  wire         wr_en       = wr_fire & wr_lane0;
  wire         sel_cfg     = wr_addr == ADDR_MODEM_CFG;
  wire         sel_hctl    = wr_addr == ADDR_HDR_CTRL;
  wire         sel_sfd     = wr_addr == ADDR_SFD_TIME;
  wire         sel_dbpsk   = wr_addr == ADDR_DBPSK_CODE;
  wire         sel_dqpsk   = wr_addr == ADDR_DQPSK_CODE;
  wire         wr_mapped   = sel_cfg | sel_hctl | sel_sfd | sel_dbpsk | sel_dqpsk |
                             (wr_addr == ADDR_RSVD_SLOT) | (wr_addr == ADDR_RX_SERVICE) |
                             (wr_addr == ADDR_RX_LEN_HI) | (wr_addr == ADDR_RX_LEN_LO) |
                             (wr_addr == ADDR_RX_CRC_HI) | (wr_addr == ADDR_RX_CRC_LO);
  // RULE5 reserved bit 0 is never stored, so a stray one does no harm
  wire [7:0]   cfg_wr_val  = {wr_byte[7:1], 1'b0};

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_data_q  <= S_AXI_WDATA[7:0];
        w_lane0_q <= S_AXI_WSTRB[0];
      end
      aw_held_q <= aw_have & ~wr_fire;
      w_held_q  <= w_have & ~wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // software-written registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      modem_config_e_q     <= RST_MODEM_CFG;
      header_control_reg_q <= RST_HDR_CTRL;
      sfd_search_time_q    <= RST_SFD_TIME;
      dbpsk_signal_code_q  <= RST_DBPSK_CODE;
      dqpsk_signal_code_q  <= RST_DQPSK_CODE;
    end else if (wr_en) begin
      if (sel_cfg) begin
        modem_config_e_q <= cfg_wr_val;
      end
      if (sel_hctl) begin
        header_control_reg_q <= wr_byte;
      end
      if (sel_sfd) begin
        sfd_search_time_q <= wr_byte;
      end
      if (sel_dbpsk) begin
        dbpsk_signal_code_q <= wr_byte;
      end
      if (sel_dqpsk) begin
        dqpsk_signal_code_q <= wr_byte;
      end
    end
  end

  // ==========================================================
  // axi read channel
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_byte;
  logic        rd_mapped;

  assign S_AXI_ARREADY = ~rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  wire         ar_take = S_AXI_ARVALID & S_AXI_ARREADY;

  always_comb begin
    rd_byte   = 8'h00;
    rd_mapped = 1'b1;
    if (S_AXI_ARADDR == ADDR_MODEM_CFG) begin
      rd_byte = modem_config_e_q;
    end else if (S_AXI_ARADDR == ADDR_HDR_CTRL) begin
      rd_byte = header_control_reg_q;
    end else if (S_AXI_ARADDR == ADDR_RSVD_SLOT) begin
      rd_byte = 8'h00;
    end else if (S_AXI_ARADDR == ADDR_SFD_TIME) begin
      rd_byte = sfd_search_time_q;
    end else if (S_AXI_ARADDR == ADDR_DBPSK_CODE) begin
      rd_byte = dbpsk_signal_code_q;
    end else if (S_AXI_ARADDR == ADDR_DQPSK_CODE) begin
      rd_byte = dqpsk_signal_code_q;
    end else if (S_AXI_ARADDR == ADDR_RX_SERVICE) begin
      rd_byte = rx_service_field_q;
    end else if (S_AXI_ARADDR == ADDR_RX_LEN_HI) begin
      rd_byte = rx_length_high_q;
    end else if (S_AXI_ARADDR == ADDR_RX_LEN_LO) begin
      rd_byte = rx_length_low_q;
    end else if (S_AXI_ARADDR == ADDR_RX_CRC_HI) begin
      rd_byte = rx_header_crc_high_q;
    end else if (S_AXI_ARADDR == ADDR_RX_CRC_LO) begin
      rd_byte = rx_header_crc_low_q;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // header capture
  // captures every header, crc good or not, so software can inspect a bad one
  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_service_field_q   <= 8'h00;
      rx_length_high_q     <= 8'h00;
      rx_length_low_q      <= 8'h00;
      rx_header_crc_high_q <= 8'h00;
      rx_header_crc_low_q  <= 8'h00;
      RX_IS_DBPSK          <= 1'b0;
      RX_IS_DQPSK          <= 1'b0;
    end else if (HDR_VALID) begin
      // RULE14 one update per header
      // RULE9 service field capture
      rx_service_field_q   <= HDR.service;
      // RULE10 length byte capture
      rx_length_high_q     <= HDR.length[15:8];
      rx_length_low_q      <= HDR.length[7:0];
      // RULE11 crc byte capture
      rx_header_crc_high_q <= HDR.crc[15:8];
      rx_header_crc_low_q  <= HDR.crc[7:0];
      // RULE7 dbpsk detect by code compare
      RX_IS_DBPSK          <= HDR.signal == dbpsk_signal_code_q;
      // RULE8 dqpsk detect by code compare
      RX_IS_DQPSK          <= HDR.signal == dqpsk_signal_code_q;
    end
  end

  // ==========================================================
  // transmit signalling code and crc coverage
  wire [1:0]   crc_mode = header_control_reg_q[1:0];
  wire [3:0]   cover_d  = (crc_mode == CRC_MODE1) ? (4'h1 << COVER_SFD) :
                          (crc_mode == CRC_MODE2) ? ((4'h1 << COVER_SFD) | (4'h1 << COVER_LENGTH)) :
                          (crc_mode == CRC_MODE3) ? ((4'h1 << COVER_SIGNAL) | (4'h1 << COVER_SERVICE) |
                                                     (4'h1 << COVER_LENGTH)) : 4'h0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      TX_SIGNAL_CODE <= RST_DBPSK_CODE;
      CRC_COVER      <= 4'h0;
    end else begin
      // RULE7 RULE8 code inserted in the transmitted field
      TX_SIGNAL_CODE <= TX_QPSK_SEL ? dqpsk_signal_code_q : dbpsk_signal_code_q;
      // RULE13 coverage from the header control mode
      CRC_COVER      <= cover_d;
    end
  end

  // ==========================================================
  // power enable pin synchroniser
  logic        pe_meta_q;
  logic        pe_sync_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pe_meta_q <= 1'b0;
      pe_sync_q <= 1'b0;
    end else begin
      pe_meta_q <= RECEIVE_POWER_ENABLE;
      pe_sync_q <= pe_meta_q;
    end
  end

  // ==========================================================
  // modem ready sequencing
  dsh_mr_state_type mr_q;
  dsh_mr_state_type mr_d;
  wire         early_en = modem_config_e_q[CFG_EARLY_BIT];

  always_comb begin
    mr_d = mr_q;
    case (mr_q)
      MR_OFF: begin
        if (pe_sync_q && DWELL_DONE) begin
          // RULE4 early ready skips the sfd wait
          mr_d = early_en ? MR_READY : MR_WAIT_SFD;
        end
      end
      MR_WAIT_SFD: begin
        if (SFD_MATCH) begin
          mr_d = MR_READY;
        end else if (SFD_TIMEOUT) begin
          mr_d = MR_OFF;
        end
      end
      MR_READY: begin
        if (FRAME_END) begin
          mr_d = MR_OFF;
        end
      end
      default: begin
        mr_d = MR_OFF;
      end
    endcase
    // a modem reset by power enable drops ready but not the busy counter
    if (!pe_sync_q) begin
      mr_d = MR_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mr_q <= MR_OFF;
    end else begin
      mr_q <= mr_d;
    end
  end

  // ready is not aligned to the receive bit clock when it comes early
  assign MODEM_READY_OUT = mr_q == MR_READY;

  // ==========================================================
  // sub-blocks
  dsh_busy_ctr u_busy (
    .clk       (CLK),
    .rst       (RST),
    .enable    (modem_config_e_q[CFG_LEN_EN_BIT]),
    .units_us  (modem_config_e_q[CFG_UNITS_BIT]),
    // RULE2 only a passed crc loads the counter
    .load      (HDR_VALID & HDR_CRC_OK),
    .length    (HDR.length),
    .bit_tick  (BIT_TICK),
    .bpsk_tick (BPSK_TICK),
    .busy      (CCA_BUSY)
  );

  dsh_sfd_timer u_sfd (
    .clk         (CLK),
    .rst         (RST),
    .start       (SFD_SEARCH_START),
    .found       (SFD_MATCH),
    .symbol_tick (SYMBOL_TICK),
    .limit       (sfd_search_time_q),
    .timeout     (SFD_TIMEOUT)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_early_dwell;
    mr_q == MR_OFF && pe_sync_q && DWELL_DONE && early_en;
  endsequence
  sequence s_late_dwell;
    mr_q == MR_OFF && pe_sync_q && DWELL_DONE && !early_en;
  endsequence

  a_early_ready_now: assert property (s_early_dwell |=> MODEM_READY_OUT) // RULE4
    else $error("early ready not raised after dwell");
  a_late_ready_wait: assert property (s_late_dwell |=> !MODEM_READY_OUT) // RULE4
    else $error("ready raised before sfd match");
  a_cfg_rsvd_zero: assert property (modem_config_e_q[CFG_RSVD_BIT] == 1'b0) // RULE5
    else $error("reserved config bit stored");
  a_crc_fail_noload: assert property (HDR_VALID && !HDR_CRC_OK && !CCA_BUSY && !BIT_TICK && !BPSK_TICK
                                      |=> !CCA_BUSY) // RULE2
    else $error("bad crc header loaded busy counter");
  a_busy_survives_pe: assert property (CCA_BUSY && !pe_sync_q && !BIT_TICK && !BPSK_TICK && !HDR_VALID
                                       && !wr_en |=> CCA_BUSY) // RULE3
    else $error("modem reset cleared busy counter");
  a_len_capture: assert property (HDR_VALID |=> {rx_length_high_q, rx_length_low_q} == $past(HDR.length)) // RULE10
    else $error("length capture mismatch");
  a_crc_capture: assert property (HDR_VALID |=> {rx_header_crc_high_q, rx_header_crc_low_q} == $past(HDR.crc)) // RULE11
    else $error("crc capture mismatch");
  a_service_capture: assert property (HDR_VALID |=> rx_service_field_q == $past(HDR.service)) // RULE9
    else $error("service capture mismatch");
  a_capture_hold: assert property (!HDR_VALID |=> $stable(rx_service_field_q) && $stable(rx_length_low_q)) // RULE14
    else $error("capture changed without header");
  a_dqpsk_detect: assert property (HDR_VALID && HDR.signal == dqpsk_signal_code_q |=> RX_IS_DQPSK) // RULE8
    else $error("dqpsk not detected");
  a_dbpsk_detect: assert property (HDR_VALID && HDR.signal == dbpsk_signal_code_q |=> RX_IS_DBPSK) // RULE7
    else $error("dbpsk not detected");
  a_cover_mode2: assert property (crc_mode == CRC_MODE2 |=> CRC_COVER == 4'h9) // RULE13
    else $error("mode 2 coverage wrong");
  a_busy_needs_en: assert property (CCA_BUSY |-> modem_config_e_q[CFG_LEN_EN_BIT]) // RULE1
    else $error("busy while counter disabled");
  a_sfd_timeout_off: assert property (mr_q == MR_WAIT_SFD && SFD_TIMEOUT && !SFD_MATCH |=> mr_q == MR_OFF) // RULE6
    else $error("ready wait survived sfd timeout");
  a_bresp_after_wr: assert property (wr_fire |=> S_AXI_BVALID ##0 !S_AXI_AWREADY)
    else $error("write response missing");

endmodule

// ==== dsh_pkg.sv ====
// dsh_pkg: constants and types for the received-header configuration register bank
// Behaviour
// RULE1: with the length-counter enable set, a counter shows the channel busy for the received length, else it is off.
// RULE2: the busy counter loads only from a header whose crc check passed.
// RULE3: only the hardware reset clears the busy counter, a modem reset through power enable leaves it running.
// RULE4: with early-ready set, modem ready rises at the end of the antenna dwell without waiting for the sfd match.
// RULE5: software always writes zero to bit 0 of the modem configuration register, which is reserved.
// RULE6: the sfd search is limited to the programmed 8-bit count of symbol periods.
// RULE7: the dbpsk code goes into the transmitted signalling field and detects dbpsk on receive.
// RULE8: the dqpsk code goes into the transmitted signalling field and detects dqpsk on receive.
// RULE9: the received service field is captured into a readable register.
// RULE10: the received 16-bit length is captured into readable high and low byte registers.
// RULE11: the received 16-bit crc is captured into readable high and low byte registers.
// RULE12: with the units bit set the busy counter counts microseconds at the bpsk rate, else it counts bits.
// RULE13: crc coverage is sfd in mode 1, sfd and length in mode 2, signalling, service and length in mode 3.
// RULE14: captured header registers update once per header and hold until the next one.
package dsh_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_HDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_MODEM_CFG  = 8'h9c;
  localparam logic [7:0] ADDR_RSVD_SLOT  = 8'ha0;
  localparam logic [7:0] ADDR_SFD_TIME   = 8'ha4;
  localparam logic [7:0] ADDR_DBPSK_CODE = 8'ha8;
  localparam logic [7:0] ADDR_DQPSK_CODE = 8'hac;
  localparam logic [7:0] ADDR_RX_SERVICE = 8'hb0;
  localparam logic [7:0] ADDR_RX_LEN_HI  = 8'hb4;
  localparam logic [7:0] ADDR_RX_LEN_LO  = 8'hb8;
  localparam logic [7:0] ADDR_RX_CRC_HI  = 8'hbc;
  localparam logic [7:0] ADDR_RX_CRC_LO  = 8'hc0;

  // ==========================================================
  // field positions
  localparam int CFG_UNITS_BIT  = 6;
  localparam int CFG_LEN_EN_BIT = 2;
  localparam int CFG_EARLY_BIT  = 1;
  localparam int CFG_RSVD_BIT   = 0;
  localparam int COVER_SFD      = 0;
  localparam int COVER_SIGNAL   = 1;
  localparam int COVER_SERVICE  = 2;
  localparam int COVER_LENGTH   = 3;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_MODEM_CFG  = 8'h00;
  localparam logic [7:0] RST_HDR_CTRL   = 8'h00;
  localparam logic [7:0] RST_SFD_TIME   = 8'hff;
  localparam logic [7:0] RST_DBPSK_CODE = 8'h0a;
  localparam logic [7:0] RST_DQPSK_CODE = 8'h14;

  // ==========================================================
  // crc coverage modes and axi responses
  localparam logic [1:0] CRC_MODE1  = 2'h1;
  localparam logic [1:0] CRC_MODE2  = 2'h2;
  localparam logic [1:0] CRC_MODE3  = 2'h3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0]  signal;
    logic [7:0]  service;
    logic [15:0] length;
    logic [15:0] crc;
  } dsh_hdr_type;

  typedef enum logic [1:0] {MR_OFF, MR_WAIT_SFD, MR_READY} dsh_mr_state_type;

endpackage

// ==== dsh_busy_ctr.sv ====
// dsh_busy_ctr: channel-busy length counter for clear channel assessment
`timescale 1ns/1ps
module dsh_busy_ctr
  import dsh_pkg::*;
(
  // clock and hardware reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        enable,
  input  wire logic        units_us,
  input  wire logic        load,
  input  wire logic [15:0] length,
  input  wire logic        bit_tick,
  input  wire logic        bpsk_tick,
  // status
  output logic             busy
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire         tick     = units_us ? bpsk_tick : bit_tick;
  wire         do_load  = enable & load;

  // RULE12 rate select by units bit
  // RULE2 load only on passed crc (load is crc-qualified)
  always_comb begin
    cnt_d = cnt_q;
    if (do_load) begin
      cnt_d = length;
    end else if (enable && tick && cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  // RULE3 only the hardware reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // RULE1 busy while enabled and counting
  assign busy = enable & (cnt_q != 16'h0000);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_after_load: assert property (do_load && length != 16'h0000 |=> busy) // RULE1
    else $error("busy not raised after load");
  a_hold_no_tick: assert property (enable && !load && !tick |=> cnt_q == $past(cnt_q)) // RULE12
    else $error("counter moved without its tick");

endmodule

// ==== dsh_sfd_timer.sv ====
// dsh_sfd_timer: limits the sfd search to a programmed count of symbol periods
`timescale 1ns/1ps
module dsh_sfd_timer
  import dsh_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // search control
  input  wire logic       start,
  input  wire logic       found,
  input  wire logic       symbol_tick,
  input  wire logic [7:0] limit,
  // result
  output logic            timeout
);

  logic       active_q;
  logic [7:0] cnt_q;
  wire        expire = active_q & symbol_tick & (cnt_q == limit);

  // RULE6 one count step per symbol period
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      cnt_q    <= 8'h00;
      timeout  <= 1'b0;
    end else begin
      timeout <= expire & ~found;
      if (start) begin
        active_q <= 1'b1;
        cnt_q    <= 8'h00;
      end else if (found || expire) begin
        active_q <= 1'b0;
      end else if (active_q && symbol_tick) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_timeout_cause: assert property (timeout |-> $past(active_q) && $past(cnt_q) == $past(limit)) // RULE6
    else $error("sfd timeout without full count");

endmodule

// ==== dsh_host.sv ====
// dsh_host: axi4-lite master model of the host controller
`timescale 1ns/1ps
module dsh_host
  import dsh_pkg::*;
(
  // clock
  input  wire logic        clk,
  // write side
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read side
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // =========================================================
  // idle levels; ready stays high, the host never stalls
  initial begin
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    wstrb = 4'h1;
    bready = 1'b1;
    rready = 1'b1;
  end
  // =========================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= (a == ADDR_MODEM_CFG) ? {d[31:1], 1'b0} : d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule

// ==== dsh_regs_tb.sv ====
// dsh_regs_tb: self-checking bench for the header register bank
`timescale 1ns/1ps
module dsh_regs_tb;
  import dsh_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} dsh_row_type;
  logic CLK = 0, RST = 1, hv = 0, ok = 0, pe = 0, qs = 0;
  logic [6:0] stb = '0;
  dsh_hdr_type hdr = '0;
  logic [7:0] awaddr, araddr, txc;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cov;
  logic [1:0] bresp, rresp;
  logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr, busy, mrdy, sto, rxb, rxq;
  int error_cnt = 0, n_tests = 0;
  logic [3:0] cov_exp [3] = '{4'h1, 4'h9, 4'he};
  dsh_row_type rows [8] = '{
    '{8'ha4, 8'h3c, 8'h3c, RESP_OKAY},
    '{8'ha8, 8'h55, 8'h55, RESP_OKAY},
    '{8'hac, 8'h66, 8'h66, RESP_OKAY},
    '{8'h9c, 8'h46, 8'h46, RESP_OKAY},
    '{8'hb0, 8'hff, 8'h00, RESP_OKAY},
    '{8'ha0, 8'h12, 8'h00, RESP_OKAY},
    '{8'hf0, 8'h12, 8'h00, RESP_SLVERR},
    '{8'h08, 8'h03, 8'h03, RESP_OKAY}};
  initial forever #25 CLK = ~CLK;
  dsh_host u_dsh_host (.clk(CLK), .awaddr(awaddr), .awvalid(awv), .awready(awr), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wv), .wready(wrd), .bresp(bresp), .bvalid(bv), .bready(br), .araddr(araddr), .arvalid(arv),
    .arready(arr), .rdata(rdata), .rresp(rresp), .rvalid(rv), .rready(rr));
  dsh_regs u_dsh_regs (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr), .HDR_VALID(hv), .HDR(hdr), .HDR_CRC_OK(ok), .DWELL_DONE(stb[0]),
    .SFD_SEARCH_START(stb[1]), .SFD_MATCH(stb[2]), .FRAME_END(stb[3]), .SYMBOL_TICK(stb[4]),
    .BIT_TICK(stb[5]), .BPSK_TICK(stb[6]), .RECEIVE_POWER_ENABLE(pe), .TX_QPSK_SEL(qs), .CCA_BUSY(busy),
    .MODEM_READY_OUT(mrdy), .SFD_TIMEOUT(sto), .TX_SIGNAL_CODE(txc), .RX_IS_DBPSK(rxb), .RX_IS_DQPSK(rxq),
    .CRC_COVER(cov));
  // =========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_dsh_host.wr(a, {24'h0, d}, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_dsh_host.rd(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  // one-cycle strobe, then settle for sampling
  task automatic pulse(input int i);
    @(posedge CLK) stb[i] <= 1'b1;
    @(posedge CLK) stb[i] <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic send(input dsh_hdr_type h, input logic c);
    @(posedge CLK) {hdr, ok, hv} <= {h, c, 1'b1};
    @(posedge CLK) hv <= 1'b0;
    @(negedge CLK);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // =========================================================
  // watchdog
  initial begin
    #(50 * 5000);
    error_cnt++;
    end_of_test;
  end
  // =========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rdc(ADDR_SFD_TIME, RST_SFD_TIME, RESP_OKAY);
    rdc(ADDR_DQPSK_CODE, RST_DQPSK_CODE, RESP_OKAY);
    chk({24'h0, txc}, {24'h0, RST_DBPSK_CODE});
    foreach (rows[i]) begin
      wrc(rows[i].a, rows[i].d, rows[i].r);
      rdc(rows[i].a, rows[i].e, rows[i].r);
    end
    for (int m = 1; m <= 3; m++) begin
      wrc(ADDR_HDR_CTRL, 8'(m), RESP_OKAY);
      repeat (2) @(negedge CLK);
      chk({28'h0, cov}, {28'h0, cov_exp[m-1]});
    end
    @(posedge CLK) qs <= 1'b1;
    repeat (2) @(negedge CLK);
    chk({24'h0, txc}, 32'h66);
    // modem ready with early-ready set, then sfd timer at limit 1
    @(posedge CLK) pe <= 1'b1;
    repeat (4) @(negedge CLK);
    pulse(0);
    chk({31'h0, mrdy}, 32'h1);
    pulse(3);
    chk({31'h0, mrdy}, 32'h0);
    wrc(ADDR_MODEM_CFG, 8'h44, RESP_OKAY);
    pulse(0);
    chk({31'h0, mrdy}, 32'h0);
    wrc(ADDR_SFD_TIME, 8'h01, RESP_OKAY);
    pulse(1);
    pulse(4);
    chk({31'h0, sto}, 32'h0);
    pulse(4);
    chk({31'h0, sto}, 32'h1);
    // failing crc must not load the busy counter
    send('{8'h66, 8'h11, 16'h0005, 16'hbeef}, 1'b0);
    chk({30'h0, busy, rxq}, 32'h1);
    send('{8'h55, 8'h5a, 16'h0002, 16'h1234}, 1'b1);
    chk({30'h0, busy, rxb}, 32'h3);
    // power enable drop is a modem reset only
    @(posedge CLK) pe <= 1'b0;
    repeat (4) @(negedge CLK);
    chk({31'h0, busy}, 32'h1);
    pulse(5);
    chk({31'h0, busy}, 32'h1);
    pulse(6);
    pulse(6);
    chk({31'h0, busy}, 32'h0);
    rdc(ADDR_RX_SERVICE, 8'h5a, RESP_OKAY);
    rdc(ADDR_RX_LEN_HI, 8'h00, RESP_OKAY);
    rdc(ADDR_RX_LEN_LO, 8'h02, RESP_OKAY);
    rdc(ADDR_RX_CRC_HI, 8'h12, RESP_OKAY);
    rdc(ADDR_RX_CRC_LO, 8'h34, RESP_OKAY);
    // mid-run hardware reset must clear a loaded busy counter
    send('{8'h55, 8'h00, 16'h0007, 16'h0000}, 1'b1);
    @(posedge CLK) RST <= 1'b1;
    @(posedge CLK) RST <= 1'b0;
    wrc(ADDR_MODEM_CFG, 8'h04, RESP_OKAY);
    chk({31'h0, busy}, 32'h0);
    end_of_test;
  end
endmodule
